// >>> rtl/pgfsr_params.svh
// Offsets, field positions, reset values and timing counts of the power-good status bank.
// Included by the package users; definitions only.
`ifndef PGFSR_PARAMS_SVH
`define PGFSR_PARAMS_SVH

`define PGFSR_OFS_STATE        8'h18
`define PGFSR_OFS_MASK         8'h19
`define PGFSR_OFS_UV           8'h1A
`define PGFSR_OFS_OV           8'h1B
`define PGFSR_OFS_DLY          8'h17

`define PGFSR_EN_BIT           7
`define PGFSR_UV_CHANS         7
`define PGFSR_OV_CHANS         6
`define PGFSR_DLY_UV_LSB       4
`define PGFSR_DLY_OV_LSB       0

`define PGFSR_RST_FLAGS        8'h00
`define PGFSR_RST_STATE        8'h00
`define PGFSR_DLY_OFF          2'h3

`define PGFSR_CLK_HZ           25000000
// Delays in microseconds
`define PGFSR_UV_DLY1_US       21000
`define PGFSR_UV_DLY2_US       45000
`define PGFSR_OV_DLY1_US       1300
`define PGFSR_OV_DLY2_US       3400
// Times convert exactly to whole cycles, 25 per microsecond, with no rounding
`define PGFSR_US2CYC(us)       ((((us) * 64'd25) + 64'd0))

`endif

// >>> rtl/pgfsr_pkg.sv
// Types shared by the power-good status bank.
// Assumes the params header for numeric constants.
package pgfsr_pkg;
   typedef logic [7:0] pgfsr_byte_t;
   typedef logic [1:0] pgfsr_dly_t;
endpackage

// >>> rtl/pgfsr_prot_chan.sv
// One protection channel: qualifies a fault by a selectable delay.
// Assumes a synchronised fault level from the same clock domain.
`timescale 1ns/100ps
`include "pgfsr_params.svh"

module pgfsr_prot_chan #(
   parameter int unsigned DLY1 = 100,
   parameter int unsigned DLY2 = 200
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                fault,
   input  wire pgfsr_pkg::pgfsr_dly_t delaySel,
   output logic                     trip
);
   import pgfsr_pkg::*;

   logic [31:0] count;
   logic [31:0] limit;

   always_comb begin
      case (delaySel)
         2'h1:    limit = DLY1;
         2'h2:    limit = DLY2;
         default: limit = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 32'h0;
      end else if (!fault || delaySel == `PGFSR_DLY_OFF) begin
         count <= 32'h0;
      end else if (count < limit) begin
         count <= count + 32'h1;
      end
   end

   always_comb begin
      trip = fault && (delaySel != `PGFSR_DLY_OFF) && (count >= limit);
   end
endmodule // pgfsr_prot_chan

// >>> rtl/pgfsr_regs.sv
// Power-good status, mask and protection flag registers with active-low fault output.
// Assumes a byte-wide register port from the serial-interface decoder, same clock.
// Contract
// - Bit 7 of power-good state shows the enable pin level, default 0.
// - Bits 6..0 show channel 7..1 power good, default 0.
// - Mask bit 0 routes channel power good to fault; 1 excludes it.
// - Mask register read/write, bit 7 unused, reset value from fuses.
// - Undervoltage flags set on detected fault, bits 6..0 for channels 7..1.
// - Overvoltage flags bits 5..0 for channels 6..1, bits 7,6 unused.
// - Flags are sticky; writing 1 clears, writing 0 leaves unchanged.
// - Each mask bit affects only its own channel.
// - Flags set only after selected delay; code 11 disables protection.
`timescale 1ns/100ps
`include "pgfsr_params.svh"

module pgfsr_regs #(
   parameter int unsigned UV_DLY1_CYC = `PGFSR_UV_DLY1_US * 25,
   parameter int unsigned UV_DLY2_CYC = `PGFSR_UV_DLY2_US * 25,
   parameter int unsigned OV_DLY1_CYC = `PGFSR_OV_DLY1_US * 25,
   parameter int unsigned OV_DLY2_CYC = `PGFSR_OV_DLY2_US * 25
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  enablePin,
   input  wire logic [6:0]            chanGood,
   input  wire logic [6:0]            uvFault,
   input  wire logic [5:0]            ovFault,
   input  wire pgfsr_pkg::pgfsr_byte_t fuseMask,
   input  wire pgfsr_pkg::pgfsr_byte_t fuseDelay,
   input  wire pgfsr_pkg::pgfsr_byte_t regAddr,
   input  wire logic                  regWrite,
   input  wire pgfsr_pkg::pgfsr_byte_t regWdata,
   input  wire logic                  regRead,
   output pgfsr_pkg::pgfsr_byte_t     regRdata,
   output logic                       fault_n
);
   import pgfsr_pkg::*;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [19:0] syncA;
   logic [19:0] syncB;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA <= 20'h00000;
         syncB <= 20'h00000;
      end else begin
         syncA <= {enablePin, chanGood, uvFault, ovFault[4:0]};
         syncB <= syncA;
      end
   end
   logic ovTopA;
   logic ovTopB;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovTopA <= 1'b0;
         ovTopB <= 1'b0;
      end else begin
         ovTopA <= ovFault[5];
         ovTopB <= ovTopA;
      end
   end

   logic       enSync;
   logic [6:0] goodSync;
   logic [6:0] uvSync;
   logic [5:0] ovSync;
   assign enSync   = syncB[19];
   assign goodSync = syncB[18:12];
   assign uvSync   = syncB[11:5];
   assign ovSync   = {ovTopB, syncB[4:0]};

   // ****************************************
   // Fuse capture after reset release
   // ****************************************
   // Fuses are sampled by a clocked load, never through the async reset
   logic       fuseLoaded;
   logic [6:0] mask;
   logic [1:0] uvDelaySel;
   logic [1:0] ovDelaySel;
   logic       wrMask;
   logic       wrDly;
   assign wrMask = regWrite && regAddr == `PGFSR_OFS_MASK;
   assign wrDly  = regWrite && regAddr == `PGFSR_OFS_DLY;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fuseLoaded <= 1'b0;
      end else begin
         fuseLoaded <= 1'b1;
      end
   end

   // Synchronised pins hold reset zeros for two edges after release;
   // without this gate the fault pin would pulse low once at start-up
   logic syncValid;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syncValid <= 1'b0;
      end else begin
         syncValid <= fuseLoaded;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask <= 7'h7F;
      end else if (!fuseLoaded) begin
         mask <= fuseMask[6:0];
      end else if (wrMask) begin
         mask <= regWdata[6:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         uvDelaySel <= `PGFSR_DLY_OFF;
         ovDelaySel <= `PGFSR_DLY_OFF;
      end else if (!fuseLoaded) begin
         uvDelaySel <= fuseDelay[`PGFSR_DLY_UV_LSB +: 2];
         ovDelaySel <= fuseDelay[`PGFSR_DLY_OV_LSB +: 2];
      end else if (wrDly) begin
         uvDelaySel <= regWdata[`PGFSR_DLY_UV_LSB +: 2];
         ovDelaySel <= regWdata[`PGFSR_DLY_OV_LSB +: 2];
      end
   end

   // ****************************************
   // Protection qualification
   // ****************************************
   logic [6:0] uvTrip;
   logic [5:0] ovTrip;
   genvar g;
   generate
      for (g = 0; g < `PGFSR_UV_CHANS; g++) begin : gUv
         pgfsr_prot_chan #(.DLY1(UV_DLY1_CYC), .DLY2(UV_DLY2_CYC)) uChan (
            .clk      (clk),
            .rst_n    (rst_n),
            .fault    (uvSync[g]),
            .delaySel (uvDelaySel),
            .trip     (uvTrip[g])
         );
      end
      for (g = 0; g < `PGFSR_OV_CHANS; g++) begin : gOv
         pgfsr_prot_chan #(.DLY1(OV_DLY1_CYC), .DLY2(OV_DLY2_CYC)) uChan (
            .clk      (clk),
            .rst_n    (rst_n),
            .fault    (ovSync[g]),
            .delaySel (ovDelaySel),
            .trip     (ovTrip[g])
         );
      end
   endgenerate

   // ****************************************
   // Sticky flags
   // ****************************************
   logic [6:0] uvFlags;
   logic [5:0] ovFlags;
   logic       wrUv;
   logic       wrOv;
   assign wrUv = regWrite && regAddr == `PGFSR_OFS_UV;
   assign wrOv = regWrite && regAddr == `PGFSR_OFS_OV;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         uvFlags <= 7'h00;
      end else begin
         uvFlags <= (uvFlags & ~(wrUv ? regWdata[6:0] : 7'h00)) | uvTrip;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovFlags <= 6'h00;
      end else begin
         ovFlags <= (ovFlags & ~(wrOv ? regWdata[5:0] : 6'h00)) | ovTrip;
      end
   end

   // ****************************************
   // Fault output
   // ****************************************
   // per-channel gating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_n <= 1'b1;
      end else begin
         fault_n <= syncValid ? ~|(~goodSync & ~mask) : 1'b1;
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            `PGFSR_OFS_STATE: regRdata <= {enSync, goodSync};
            `PGFSR_OFS_MASK:  regRdata <= {1'b0, mask};
            `PGFSR_OFS_UV:    regRdata <= {1'b0, uvFlags};
            `PGFSR_OFS_OV:    regRdata <= {2'h0, ovFlags};
            `PGFSR_OFS_DLY:   regRdata <= {2'h0, uvDelaySel, 2'h0, ovDelaySel};
            default:          regRdata <= 8'h00;
         endcase
      end
   end
endmodule // pgfsr_regs

// >>> verification/pgfsr_monitor.sv
// Assertions on the register port and fault output of the status bank.
// Bound to pgfsr_regs; sees only its ports.
`timescale 1ns/100ps
module pgfsr_monitor (
   input wire logic                   clk,
   input wire logic                   rst_n,
   input wire logic                   enablePin,
   input wire logic [6:0]             chanGood,
   input wire logic [6:0]             uvFault,
   input wire pgfsr_pkg::pgfsr_byte_t regAddr,
   input wire logic                   regWrite,
   input wire pgfsr_pkg::pgfsr_byte_t regWdata,
   input wire logic                   regRead,
   input wire pgfsr_pkg::pgfsr_byte_t regRdata,
   input wire logic                   fault_n
);
   import pgfsr_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Inputs pass a two-flop synchroniser, hence the steady spans
   sequence s_steadyIn; $stable({enablePin, chanGood}) [*3]; endsequence
   sequence s_allGood; (chanGood == 7'h7F) [*5]; endsequence
   sequence s_uvQuiet; (uvFault == 7'h00) [*6]; endsequence
   sequence s_uvClear; regWrite && regAddr == 8'h1A && regWdata == 8'hFF; endsequence
   a_rdata_hold: assert property (!regRead |=> $stable(regRdata))
      else $error("read data moved without a read");
   a_state_read: assert property (s_steadyIn ##0 (regRead && regAddr == 8'h18)
      |=> regRdata == $past({enablePin, chanGood})) else $error("state read wrong");
   a_low_unmapped: assert property (regRead && regAddr < 8'h17 |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_high_unmapped: assert property (regRead && regAddr > 8'h1B |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_uv_top: assert property (regRead && regAddr == 8'h1A |=> !regRdata[7])
      else $error("undervoltage bit 7 set");
   a_ov_top: assert property (regRead && regAddr == 8'h1B |=> regRdata[7:6] == 2'b00)
      else $error("overvoltage bits 7:6 set");
   a_fault_good: assert property (s_allGood |-> fault_n)
      else $error("fault low with all channels good");
   a_flag_clear: assert property (s_uvQuiet ##0 s_uvClear ##[1:3]
      (regRead && regAddr == 8'h1A) |=> regRdata == 8'h00) else $error("flag not cleared");
endmodule // pgfsr_monitor

bind pgfsr_regs pgfsr_monitor pgfsr_monitor_inst (.clk(clk), .rst_n(rst_n),
   .enablePin(enablePin), .chanGood(chanGood), .uvFault(uvFault), .regAddr(regAddr),
   .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata),
   .fault_n(fault_n));

// >>> verification/pgfsr_host.sv
// Host side of the register port: single byte reads and writes.
// Assumes its tasks are called from one process only.
`timescale 1ns/100ps
module pgfsr_host (
   input  wire logic                   clk,
   output pgfsr_pkg::pgfsr_byte_t      regAddr,
   output logic                        regWrite,
   output pgfsr_pkg::pgfsr_byte_t      regWdata,
   output logic                        regRead,
   input  wire pgfsr_pkg::pgfsr_byte_t regRdata
);
   import pgfsr_pkg::*;
   initial begin
      regAddr = 8'h00;
      regWdata = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
   end
   // Released fields show the inverse, never a stale copy
   task automatic wr(input pgfsr_byte_t a, input pgfsr_byte_t d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      regAddr <= ~a;
      regWdata <= ~d;
   endtask
   task automatic rd(input pgfsr_byte_t a, output pgfsr_byte_t d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      regAddr <= ~a;
      @(posedge clk);
      d = regRdata;
   endtask
endmodule // pgfsr_host

// >>> verification/tb_top.sv
// Self-checking bench for the power-good status bank.
// Pins driven here; registers reached through the host model.
`timescale 1ns/100ps
module tb_top;
   import pgfsr_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        enablePin = 1'b0;
   logic        regWrite, regRead, fault_n;
   logic [6:0]  chanGood = 7'h00;
   logic [6:0]  uvFault = 7'h00;
   logic [5:0]  ovFault = 6'h00;
   pgfsr_byte_t regAddr, regWdata, regRdata;
   pgfsr_byte_t fuseMask = 8'h55;
   pgfsr_byte_t fuseDelay = 8'h00;
   int          fail_count = 0;
   int          n_compared = 0;
   pgfsr_byte_t mk[5] = '{8'h55, 8'h54, 8'h56, 8'h7F, 8'h00};
   pgfsr_byte_t fx[5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
   pgfsr_byte_t dl[4] = '{8'h12, 8'h12, 8'h21, 8'h33};
   int          hd[4] = '{7, 14, 7, 20};
   pgfsr_byte_t eu[4] = '{8'h01, 8'h01, 8'h00, 8'h00};
   pgfsr_byte_t eo[4] = '{8'h00, 8'h01, 8'h01, 8'h00};
   initial begin
      forever #20 clk = ~clk;
   end
   // Short delays: 5 and 10 cycles stand for codes 01 and 10
   pgfsr_regs #(.UV_DLY1_CYC(5), .UV_DLY2_CYC(10), .OV_DLY1_CYC(5), .OV_DLY2_CYC(10))
      pgfsr_regs_inst (.clk(clk), .rst_n(rst_n), .enablePin(enablePin), .chanGood(chanGood),
      .uvFault(uvFault), .ovFault(ovFault), .fuseMask(fuseMask), .fuseDelay(fuseDelay),
      .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead),
      .regRdata(regRdata), .fault_n(fault_n));
   pgfsr_host pgfsr_host_inst (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
      .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata));
   task automatic chk(input string n, input pgfsr_byte_t e, input pgfsr_byte_t s);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rdchk(input pgfsr_byte_t a, input pgfsr_byte_t e);
      pgfsr_byte_t v;
      pgfsr_host_inst.rd(a, v);
      chk($sformatf("reg %h", a), e, v);
   endtask
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rdchk(8'h18, 8'h00);
      rdchk(8'h19, 8'h55);
      rdchk(8'h1A, 8'h00);
      rdchk(8'h1B, 8'h00);
      rdchk(8'h20, 8'h00);
      enablePin <= 1'b1;
      chanGood <= 7'h41;
      pgfsr_host_inst.wr(8'h18, 8'hFF);
      rdchk(8'h18, 8'hC1);
      chanGood <= 7'h7D;
      foreach (mk[i]) begin
         pgfsr_host_inst.wr(8'h19, mk[i]);
         rdchk(8'h19, mk[i]);
         @(negedge clk);
         chk("fault_n", fx[i], {7'h00, fault_n});
      end
      chanGood <= 7'h7F;
      uvFault <= 7'h41;
      ovFault <= 6'h21;
      repeat (5) @(posedge clk);
      uvFault <= 7'h00;
      ovFault <= 6'h00;
      repeat (4) @(posedge clk);
      rdchk(8'h1A, 8'h41);
      rdchk(8'h1B, 8'h21);
      pgfsr_host_inst.wr(8'h1A, 8'h01);
      rdchk(8'h1A, 8'h40);
      pgfsr_host_inst.wr(8'h1B, 8'hFF);
      rdchk(8'h1B, 8'h00);
      pgfsr_host_inst.wr(8'h1A, 8'hFF);
      rdchk(8'h1A, 8'h00);
      foreach (dl[i]) begin
         pgfsr_host_inst.wr(8'h17, dl[i]);
         pgfsr_host_inst.wr(8'h1A, 8'hFF);
         pgfsr_host_inst.wr(8'h1B, 8'hFF);
         uvFault <= 7'h01;
         ovFault <= 6'h01;
         repeat (hd[i]) @(posedge clk);
         uvFault <= 7'h00;
         ovFault <= 6'h00;
         repeat (4) @(posedge clk);
         rdchk(8'h1A, eu[i]);
         rdchk(8'h1B, eo[i]);
      end
      rdchk(8'h17, 8'h33);
      // Second reset mid-run with other fuse levels
      fuseMask <= 8'h2A;
      fuseDelay <= 8'h21;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("fault_n", 8'h01, {7'h00, fault_n});
      rdchk(8'h19, 8'h2A);
      rdchk(8'h17, 8'h21);
      rdchk(8'h1A, 8'h00);
      rdchk(8'h1B, 8'h00);
      rdchk(8'h18, 8'hFF);
      chanGood <= 7'h7E;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("fault_n", 8'h00, {7'h00, fault_n});
      close_out();
   end
   initial begin
      #100000;
      fail_count++;
      close_out();
   end
endmodule // tb_top
